/* File: eps_pkg.sv */
// Package with register map, field layout and timing of the emulated PHY status/ID block.
package eps_pkg;
  localparam logic [11:0] EPS_OFS_STATUS      = 12'h01c4;
  localparam logic [11:0] EPS_OFS_IDENT_UPPER = 12'h01c8;
  localparam logic [4:0]  EPS_IDX_STATUS      = 5'h01;
  localparam logic [4:0]  EPS_IDX_IDENT_UPPER = 5'h02;
  // Bit positions inside the 16-bit status word.
  localparam int EPS_BIT_T4       = 15;
  localparam int EPS_BIT_X_FD     = 14;
  localparam int EPS_BIT_X_HD     = 13;
  localparam int EPS_BIT_T_FD     = 12;
  localparam int EPS_BIT_T_HD     = 11;
  localparam int EPS_BIT_T2_FD    = 10;
  localparam int EPS_BIT_T2_HD    = 9;
  localparam int EPS_BIT_EXT_STAT = 8;
  localparam int EPS_BIT_RSVD7    = 7;
  localparam int EPS_BIT_PRE_SUP  = 6;
  localparam int EPS_BIT_AN_DONE  = 5;
  localparam int EPS_BIT_RFAULT   = 4;
  localparam int EPS_BIT_AN_ABLE  = 3;
  localparam int EPS_BIT_LINK     = 2;
  localparam int EPS_BIT_JABBER   = 1;
  localparam int EPS_BIT_EXT_CAP  = 0;
  // Fixed part of the status word, negotiation-complete bit excluded.
  localparam logic [15:0] EPS_STATUS_FIXED    = 16'h780d;
  // Identifier default; the value is arbitrary.
  localparam logic [15:0] EPS_IDENT_RESET     = 16'h0a5c;
  localparam logic [15:0] EPS_PAD_ZERO        = 16'h0000;
  // Emulated negotiation time after any reset.
  localparam int          EPS_AN_TIME_NS      = 80;
  localparam int          EPS_CLK_PERIOD_NS   = 10;
  localparam logic [3:0]  EPS_AN_CYCLES       =
    4'((EPS_AN_TIME_NS + EPS_CLK_PERIOD_NS - 1) / EPS_CLK_PERIOD_NS);
  localparam logic [3:0]  EPS_AN_RESET        = 4'h0;
endpackage

/* File: eps_an_timer.sv */
// Emulated negotiation timer that raises a done level after a fixed delay.
`timescale 1ns/1ps
module eps_an_timer
  import eps_pkg::*;
(
  input  wire logic mclk,     // Device clock.
  input  wire logic resetn,   // Asynchronous reset, active low.
  input  wire logic clkEn,    // Clock enable, freezes state when low.
  input  wire logic restart,  // Soft reset pulse restarting negotiation.
  output logic      anDone    // Negotiation has completed.
);
  import eps_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic       done;
  } eps_tmr_s;

  eps_tmr_s st_q;
  eps_tmr_s st_d;

  // Count up after reset, then hold done until the next restart.
  always_comb begin
    st_d = st_q;
    if (restart) begin
      st_d.cnt  = EPS_AN_RESET;
      st_d.done = 1'b0;
    end else if (!st_q.done) begin
      st_d.cnt = st_q.cnt + 4'h1;
      if (st_q.cnt + 4'h1 >= EPS_AN_CYCLES) begin
        st_d.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  assign anDone = st_q.done;
endmodule

/* File: eps_status_id_regs.sv */
// Status and upper identification registers of the emulated PHY.
`timescale 1ns/1ps
// What this block does
// - Registers sit in 32-bit slots; bits 31:16 pad; serial path sees 16 bits.
// - Status bits 14 and 13 report 100 Mb/s X full and half duplex.
// - Status bits 12 and 11 report 10 Mb/s full and half duplex.
// - Status bits 15, 10 and 9 for unsupported media always read zero.
// - Status bit 8, extended status, always reads zero.
// - Status bit 6 reads zero: preamble suppression not accepted.
// - Negotiation-complete bit 5 clears on reset, sets after emulated negotiation.
// - Remote fault and jabber read zero; link status reads one.
// - Status bit 3 reads one: negotiation ability.
// - Status bit 0 reads one: extended register capability.
// - Upper identifier holds a writable 16-bit field, restored on reset.
// - Status bits are read-only; writes leave them unchanged.
// - Soft reset returns the identifier to its default and clears negotiation-complete; read data registers hold.
module eps_status_id_regs
  import eps_pkg::*;
(
  input  wire logic        mclk,       // Device clock, 100 MHz.
  input  wire logic        resetn,     // Asynchronous reset, active low.
  input  wire logic        clkEn,      // Clock enable, freezes state when low.
  input  wire logic        softReset,  // Self-clearing soft reset pulse.
  input  wire logic        memRd,      // Memory-mapped read strobe.
  input  wire logic        memWr,      // Memory-mapped write strobe.
  input  wire logic [11:0] memAddr,    // Memory-mapped byte address.
  input  wire logic [31:0] memWdata,   // Memory-mapped write data.
  output logic      [31:0] memRdata,   // Memory-mapped read data.
  output logic             memHit,     // Address decodes to this block.
  input  wire logic        mgmtRd,     // Serial management read strobe.
  input  wire logic        mgmtWr,     // Serial management write strobe.
  input  wire logic [4:0]  mgmtIdx,    // Serial management register index.
  input  wire logic [15:0] mgmtWdata,  // Serial management write data.
  output logic      [15:0] mgmtRdata,  // Serial management read data.
  output logic             mgmtHit,    // Index decodes to this block.
  output logic             anComplete  // Negotiation-complete level.
);
  import eps_pkg::*;

  typedef struct packed {
    logic [15:0] ident;
    logic [31:0] memRd;
    logic [15:0] mgmtRd;
  } eps_regs_s;

  eps_regs_s st_q;
  eps_regs_s st_d;
  logic        anDone;
  logic [15:0] statusWord;
  logic        memSelSt;
  logic        memSelId;
  logic        mgmtSelSt;
  logic        mgmtSelId;

  // Negotiation runs after hard reset and again after each soft reset.
  eps_an_timer u_timer (
    .mclk    (mclk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .restart (softReset),
    .anDone  (anDone)
  );

  // Status word is built from constants plus the live negotiation flag.
  always_comb begin
    statusWord = EPS_STATUS_FIXED;
    statusWord[EPS_BIT_AN_DONE] = anDone;
    statusWord[EPS_BIT_RSVD7]   = 1'b0;
  end

  // Address decode on both access paths.
  assign memSelSt  = (memAddr == EPS_OFS_STATUS);
  assign memSelId  = (memAddr == EPS_OFS_IDENT_UPPER);
  assign mgmtSelSt = (mgmtIdx == EPS_IDX_STATUS);
  assign mgmtSelId = (mgmtIdx == EPS_IDX_IDENT_UPPER);
  assign memHit    = memSelSt | memSelId;
  assign mgmtHit   = mgmtSelSt | mgmtSelId;

  // Next state: identifier writes, registered read data, soft reset.
  always_comb begin
    st_d = st_q;
    if (memWr && memSelId) begin
      st_d.ident = memWdata[15:0];
    end else if (mgmtWr && mgmtSelId) begin
      st_d.ident = mgmtWdata;
    end
    if (memRd) begin
      st_d.memRd = {EPS_PAD_ZERO, memSelSt ? statusWord :
                    memSelId ? st_q.ident : EPS_PAD_ZERO};
    end
    if (mgmtRd) begin
      st_d.mgmtRd = mgmtSelSt ? statusWord :
                    mgmtSelId ? st_q.ident : EPS_PAD_ZERO;
    end
    if (softReset) begin
      st_d.ident = EPS_IDENT_RESET;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q.ident  <= EPS_IDENT_RESET;
      st_q.memRd  <= '0;
      st_q.mgmtRd <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  assign memRdata   = st_q.memRd;
  assign mgmtRdata  = st_q.mgmtRd;
  assign anComplete = anDone;

  property p_pad_zero;
    @(posedge mclk) disable iff (!resetn) memRdata[31:16] == EPS_PAD_ZERO;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("padding not zero");

  property p_st_fixed;
    @(posedge mclk) disable iff (!resetn)
      (memRd && clkEn && memSelSt) |=> (memRdata[15:6] == 10'h1e0);
  endproperty
  a_st_fixed: assert property (p_st_fixed) else $error("status abilities wrong");

  property p_st_low;
    @(posedge mclk) disable iff (!resetn)
      (mgmtRd && clkEn && mgmtSelSt) |=> (mgmtRdata[4:0] == 5'h0d);
  endproperty
  a_st_low: assert property (p_st_low) else $error("status low bits wrong");

  sequence s_soft;
    softReset && clkEn;
  endsequence
  property p_an_clear;
    @(posedge mclk) disable iff (!resetn) s_soft |=> !anComplete;
  endproperty
  a_an_clear: assert property (p_an_clear) else $error("negotiation flag not cleared");

  property p_an_set;
    @(posedge mclk) disable iff (!resetn)
      (s_soft ##1 (!softReset && clkEn) [*8]) |=> anComplete;
  endproperty
  a_an_set: assert property (p_an_set) else $error("negotiation never completed");

  property p_id_wr;
    @(posedge mclk) disable iff (!resetn)
      (memWr && memSelId && clkEn && !softReset) ##1 (mgmtRd && mgmtSelId && clkEn
        && !mgmtWr && !memWr && !softReset)
      |=> mgmtRdata == $past(memWdata[15:0], 2);
  endproperty
  a_id_wr: assert property (p_id_wr) else $error("identifier readback wrong");

  property p_id_rst;
    @(posedge mclk) disable iff (!resetn) s_soft |=> st_q.ident == EPS_IDENT_RESET;
  endproperty
  a_id_rst: assert property (p_id_rst) else $error("identifier not restored");

  property p_st_ro;
    @(posedge mclk) disable iff (!resetn)
      (memRd && clkEn && memSelSt) |=> memRdata[15:0] ==
        {EPS_STATUS_FIXED[15:6], $past(anComplete), EPS_STATUS_FIXED[4:0]};
  endproperty
  a_st_ro: assert property (p_st_ro) else $error("status bits changed");

  // A status read taken on the memory-mapped path.
  sequence s_st_rd;
    memRd && clkEn && memSelSt;
  endsequence

  // A status read taken on the serial path.
  sequence s_mst_rd;
    mgmtRd && clkEn && mgmtSelSt;
  endsequence

  // Both 100 Mb/s abilities are reported on the memory path.
  property p_x_abil;
    @(posedge mclk) disable iff (!resetn)
      s_st_rd |=> memRdata[EPS_BIT_X_FD] && memRdata[EPS_BIT_X_HD];
  endproperty
  a_x_abil: assert property (p_x_abil) else $error("100M ability missing");

  // Both 100 Mb/s abilities are reported on the serial path.
  property p_x_abil_m;
    @(posedge mclk) disable iff (!resetn)
      s_mst_rd |=> mgmtRdata[EPS_BIT_X_FD] && mgmtRdata[EPS_BIT_X_HD];
  endproperty
  a_x_abil_m: assert property (p_x_abil_m) else $error("serial 100M ability missing");

  // Both 10 Mb/s abilities are reported on the memory path.
  property p_t_abil;
    @(posedge mclk) disable iff (!resetn)
      s_st_rd |=> memRdata[EPS_BIT_T_FD] && memRdata[EPS_BIT_T_HD];
  endproperty
  a_t_abil: assert property (p_t_abil) else $error("10M ability missing");

  // Both 10 Mb/s abilities are reported on the serial path.
  property p_t_abil_m;
    @(posedge mclk) disable iff (!resetn)
      s_mst_rd |=> mgmtRdata[EPS_BIT_T_FD] && mgmtRdata[EPS_BIT_T_HD];
  endproperty
  a_t_abil_m: assert property (p_t_abil_m) else $error("serial 10M ability missing");

  // Unsupported media modes never show up on the memory path.
  property p_unsup;
    @(posedge mclk) disable iff (!resetn)
      s_st_rd |=> !memRdata[EPS_BIT_T4] && !memRdata[EPS_BIT_T2_FD] && !memRdata[EPS_BIT_T2_HD];
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported mode reported");

  // Unsupported media modes never show up on the serial path.
  property p_unsup_m;
    @(posedge mclk) disable iff (!resetn)
      s_mst_rd |=> !mgmtRdata[EPS_BIT_T4] && mgmtRdata[10:9] == 2'b00;
  endproperty
  a_unsup_m: assert property (p_unsup_m) else $error("serial unsupported mode");

  // No extended status register is announced.
  property p_ext_stat;
    @(posedge mclk) disable iff (!resetn)
      s_st_rd |=> !memRdata[EPS_BIT_EXT_STAT];
  endproperty
  a_ext_stat: assert property (p_ext_stat) else $error("extended status set");

  // Preamble suppression is refused on the memory path.
  property p_pre_sup;
    @(posedge mclk) disable iff (!resetn)
      s_st_rd |=> !memRdata[EPS_BIT_PRE_SUP];
  endproperty
  a_pre_sup: assert property (p_pre_sup) else $error("preamble suppression set");

  // Preamble suppression is refused on the serial path.
  property p_pre_sup_m;
    @(posedge mclk) disable iff (!resetn)
      s_mst_rd |=> !mgmtRdata[EPS_BIT_PRE_SUP];
  endproperty
  a_pre_sup_m: assert property (p_pre_sup_m) else $error("serial preamble bit set");

  // No fault, no jabber, and the link is always up.
  property p_fault;
    @(posedge mclk) disable iff (!resetn)
      s_st_rd |=> !memRdata[EPS_BIT_RFAULT] && memRdata[EPS_BIT_LINK] && !memRdata[EPS_BIT_JABBER];
  endproperty
  a_fault: assert property (p_fault) else $error("fault or link bits wrong");

  // Negotiation ability is always reported.
  property p_an_able;
    @(posedge mclk) disable iff (!resetn)
      s_st_rd |=> memRdata[EPS_BIT_AN_ABLE];
  endproperty
  a_an_able: assert property (p_an_able) else $error("negotiation ability missing");

  // Extended register capability is always reported.
  property p_ext_cap;
    @(posedge mclk) disable iff (!resetn)
      s_st_rd |=> memRdata[EPS_BIT_EXT_CAP];
  endproperty
  a_ext_cap: assert property (p_ext_cap) else $error("extended capability missing");

  // The read-back completion bit follows the live flag at the read edge.
  property p_an_bit;
    @(posedge mclk) disable iff (!resetn)
      s_st_rd |=> memRdata[EPS_BIT_AN_DONE] == $past(anComplete);
  endproperty
  a_an_bit: assert property (p_an_bit) else $error("completion bit stale");

  // Same for the serial path.
  property p_an_bit_m;
    @(posedge mclk) disable iff (!resetn)
      s_mst_rd |=> mgmtRdata[EPS_BIT_AN_DONE] == $past(anComplete);
  endproperty
  a_an_bit_m: assert property (p_an_bit_m) else $error("serial completion bit stale");

  // The reserved status bit reads zero.
  property p_rsvd7;
    @(posedge mclk) disable iff (!resetn)
      s_st_rd |=> !memRdata[EPS_BIT_RSVD7];
  endproperty
  a_rsvd7: assert property (p_rsvd7) else $error("reserved bit set");

  // Unmapped memory reads return zero.
  property p_unmapped;
    @(posedge mclk) disable iff (!resetn)
      (memRd && clkEn && !memHit) |=> memRdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Unmapped serial reads return zero.
  property p_unmapped_m;
    @(posedge mclk) disable iff (!resetn)
      (mgmtRd && clkEn && !mgmtHit) |=> mgmtRdata == 16'h0000;
  endproperty
  a_unmapped_m: assert property (p_unmapped_m) else $error("unmapped serial not zero");

  // A memory write lands its low half in the identifier.
  property p_id_mem;
    @(posedge mclk) disable iff (!resetn)
      (memWr && memSelId && clkEn && !softReset) |=> st_q.ident == $past(memWdata[15:0]);
  endproperty
  a_id_mem: assert property (p_id_mem) else $error("identifier write lost");

  // A serial write lands when no memory write competes.
  property p_id_mgmt;
    @(posedge mclk) disable iff (!resetn)
      (mgmtWr && mgmtSelId && clkEn && !softReset && !(memWr && memSelId))
      |=> st_q.ident == $past(mgmtWdata);
  endproperty
  a_id_mgmt: assert property (p_id_mgmt) else $error("serial identifier write lost");

  // Read data stands until the next read is taken.
  property p_hold;
    @(posedge mclk) disable iff (!resetn)
      !(memRd && clkEn) |=> $stable(memRdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule

/* File: eps_mgmt_station.sv */
// Management station model that issues serial register reads and writes.
`timescale 1ns/1ps
module eps_mgmt_station (
  input  wire logic        mclk,       // Device clock.
  input  wire logic [15:0] mgmtRdata,  // Read data from the block.
  output logic             mgmtRd,     // Read strobe.
  output logic             mgmtWr,     // Write strobe.
  output logic      [4:0]  mgmtIdx,    // Register index.
  output logic      [15:0] mgmtWdata   // Write data.
);
  // Start idle with both strobes low.
  initial begin
    mgmtRd = 1'b0;
    mgmtWr = 1'b0;
    mgmtIdx = 5'h1f;
    mgmtWdata = 16'h0000;
  end
  // One access held for one edge; idle lines then show the inverse, never stale data.
  task automatic xfer(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
                      output logic [15:0] rd);
    @(posedge mclk);
    mgmtRd <= !wr;
    mgmtWr <= wr;
    mgmtIdx <= idx;
    mgmtWdata <= wd;
    @(posedge mclk);
    mgmtRd <= 1'b0;
    mgmtWr <= 1'b0;
    mgmtIdx <= ~idx;
    mgmtWdata <= ~wd;
    #1 rd = mgmtRdata;
  endtask
endmodule

/* File: eps_status_id_regs_tb.sv */
// Self-checking bench for the emulated PHY status and identification registers.
`timescale 1ns/1ps
module eps_status_id_regs_tb;
  import eps_pkg::*;
  localparam logic [31:0] ST = 32'h0000_782d;
  localparam logic [31:0] ST_AN = 32'h0000_780d;
  logic        mclk, resetn, softReset, memRd, memWr, memHit;
  logic        mgmtRd, mgmtWr, mgmtHit, anComplete, clkEn;
  logic [11:0] memAddr;
  logic [31:0] memWdata, memRdata;
  logic [4:0]  mgmtIdx;
  logic [15:0] mgmtWdata, mgmtRdata, d;
  int          mismatches, nChecks;
  int          cycles = 0;
  eps_status_id_regs eps_status_id_regs_i (.mclk(mclk), .resetn(resetn), .clkEn(clkEn),
    .softReset(softReset), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memHit(memHit), .mgmtRd(mgmtRd),
    .mgmtWr(mgmtWr), .mgmtIdx(mgmtIdx), .mgmtWdata(mgmtWdata), .mgmtRdata(mgmtRdata),
    .mgmtHit(mgmtHit), .anComplete(anComplete));
  eps_mgmt_station eps_mgmt_station_i (.mclk(mclk), .mgmtRdata(mgmtRdata),
    .mgmtRd(mgmtRd), .mgmtWr(mgmtWr), .mgmtIdx(mgmtIdx), .mgmtWdata(mgmtWdata));
  // Clock generator.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Cuts a hang short.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Memory-mapped access held for one edge; a read is checked one cycle later.
  task automatic mem(input logic wr, input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    memRd <= !wr;
    memWr <= wr;
    memAddr <= a;
    memWdata <= v;
    @(posedge mclk);
    memRd <= 1'b0;
    memWr <= 1'b0;
    memWdata <= ~v;
    #1 if (!wr) chk(memRdata, v);
  endtask
  // Serial read through the station, zero-extended and checked against a 32-bit value.
  task automatic mgr(input logic [4:0] idx, input logic [31:0] v);
    eps_mgmt_station_i.xfer(1'b0, idx, 16'h0000, d);
    chk({16'h0000, d}, v);
  endtask
  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    if (mismatches == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence.
  initial begin
    {resetn, softReset, memRd, memWr} = 4'h0;
    memAddr = 12'h000;
    memWdata = 32'h0000_0000;
    {mismatches, nChecks} = 0;
    clkEn = 1'b1;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    mem(0, EPS_OFS_STATUS, ST_AN);
    repeat (10) @(posedge mclk);
    chk({31'h0, anComplete}, 32'h0000_0001);
    mem(0, EPS_OFS_STATUS, ST);
    mem(0, EPS_OFS_IDENT_UPPER, {16'h0000, EPS_IDENT_RESET});
    mem(1, EPS_OFS_STATUS, 32'hffff_ffff);
    eps_mgmt_station_i.xfer(1'b1, EPS_IDX_STATUS, 16'h0000, d);
    mem(0, EPS_OFS_STATUS, ST);
    mgr(EPS_IDX_STATUS, ST);
    mem(1, EPS_OFS_IDENT_UPPER, 32'hffff_1234);
    mem(0, EPS_OFS_IDENT_UPPER, 32'h0000_1234);
    mgr(EPS_IDX_IDENT_UPPER, 32'h0000_1234);
    eps_mgmt_station_i.xfer(1'b1, EPS_IDX_IDENT_UPPER, 16'hbeef, d);
    mem(0, EPS_OFS_IDENT_UPPER, 32'h0000_beef);
    mem(0, 12'h1cc, 32'h0000_0000);
    chk({31'h0, memHit}, 32'h0000_0000);
    mgr(5'h03, 32'h0000_0000);
    fork
      mem(1, EPS_OFS_IDENT_UPPER, 32'h0000_5a5a);
      begin
        @(posedge mclk);
        mgr(EPS_IDX_IDENT_UPPER, 32'h0000_5a5a);
      end
      begin
        repeat (2) @(posedge mclk);
        #1 chk({31'h0, mgmtHit}, 32'h0000_0001);
        chk({31'h0, memHit}, 32'h0000_0001);
      end
    join
    @(posedge mclk);
    clkEn <= 1'b0;
    mem(1, EPS_OFS_IDENT_UPPER, 32'h0000_0f0f);
    @(posedge mclk);
    clkEn <= 1'b1;
    mem(0, EPS_OFS_IDENT_UPPER, 32'h0000_5a5a);
    @(posedge mclk);
    softReset <= 1'b1;
    @(posedge mclk);
    softReset <= 1'b0;
    mem(0, EPS_OFS_STATUS, ST_AN);
    chk({31'h0, anComplete}, 32'h0000_0000);
    mem(0, EPS_OFS_IDENT_UPPER, {16'h0000, EPS_IDENT_RESET});
    repeat (10) @(posedge mclk);
    mem(1, EPS_OFS_IDENT_UPPER, 32'h0000_1111);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    mem(0, EPS_OFS_STATUS, ST_AN);
    mem(0, EPS_OFS_IDENT_UPPER, {16'h0000, EPS_IDENT_RESET});
    repeat (10) @(posedge mclk);
    mgr(EPS_IDX_STATUS, ST);
    report_and_stop();
  end
endmodule
